// [adc_readout_pkg.sv]
package adc_readout_pkg;

	// Result word
	localparam int RESULT_W = 24;

	// Reference clock, 10 MHz
	localparam int CLK_PERIOD_NS = 100;

	// Crystal period in tenths of ns (30.5176 us)
	localparam int CRYSTAL_TIMEBASE_PERIOD_NS_X10 = 305176;
	// Half crystal period in reference cycles, rounded up
	localparam int CRYSTAL_TIMEBASE_HALF_CYC =
		(CRYSTAL_TIMEBASE_PERIOD_NS_X10 + 20 * CLK_PERIOD_NS - 1) / (20 * CLK_PERIOD_NS);

	// Conversion period (50.54 ms) in ns and in reference cycles
	localparam int CONV_PERIOD_NS = 50540000;
	localparam int CONV_CYC_DEF   = CONV_PERIOD_NS / CLK_PERIOD_NS;

	// Conversion periods to wait after the input pair changes
	localparam logic [1:0] SETTLE_CONVS = 2'h2;

	// Serial data pin: value and active-low output enable
	typedef struct packed {
		logic data;
		logic oe_n;
	} dout_pin_s;

	// Master-role clock generator states
	typedef enum logic [3:0] {
		M_IDLE = 4'b0001,
		M_LEAD = 4'b0010,
		M_LOW  = 4'b0100,
		M_HIGH = 4'b1000
	} mstate_e;

endpackage

// [adc_readout_serial_port.sv]
`timescale 1ns/1ns
// What this block does
// - A new result is produced every 50.54 ms conversion period.
// - After input pair change, results count only after two full periods.
// - Role pin low selects slave with external clock, high selects master.
// - Serial output changes after each falling clock edge; reader samples rising.
// - Each bit appears within 80 ns after the falling edge, never before.
// - Select falling starts driving the output within 80 ns.
// - Select rising releases the output within 10 to 80 ns.
// - After the last rising edge of a result the output returns high.
// - Master clock high and low phases each last half a crystal period.
// - Master first falling edge comes 0.5 to 1.5 crystal periods after ready.
module adc_readout_serial_port
	import adc_readout_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYC_DEF,
	parameter int HALF_CYC = CRYSTAL_TIMEBASE_HALF_CYC
) (
	// Reference clock and reset
	input  wire logic                   ref_clk_i,
	input  wire logic                   rst_n_i,
	// Serial link pins
	input  wire logic                   link_sclk_i,
	input  wire logic                   cs_n_i,
	output logic                        sclk_o,
	output logic                        sclk_oe_n_o,
	output adc_readout_pkg::dout_pin_s  dout_o,
	// Configuration pins
	input  wire logic                   role_master_i,
	input  wire logic                   input_pair_select_i,
	// Converter core
	input  wire logic [RESULT_W-1:0]    result_i,
	output logic                        settled_o
);
	import adc_readout_pkg::*;

	localparam int BIT_W = $clog2(RESULT_W + 1);
	localparam int CONV_W = $clog2(CONV_CYC + 1);
	localparam int HALF_W = $clog2(HALF_CYC + 1);
	localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(RESULT_W);

	// Pin synchronisers (reference domain)
	logic [1:0] cs_sync_q;
	logic [1:0] role_sync_q;
	logic [1:0] sel_sync_q;
	logic [1:0] done_sync_q;
	logic       sel_prev_q;
	logic       done_prev_q;

	logic                  role_q;
	logic [CONV_W-1:0]     conv_cnt_q;
	logic [1:0]            settle_q;
	logic [RESULT_W-1:0]   word_q;
	logic                  pending_q;
	mstate_e               mstate_q;
	logic [HALF_W-1:0]     half_cnt_q;
	logic [BIT_W-1:0]      mbit_q;
	logic                  m_dout_q;
	logic                  sclk_q;
	logic                  m_finish;

	// Link domain
	logic [BIT_W-1:0]      s_cnt_q;
	logic                  s_bit_q;
	logic                  s_done_q;

	logic cs_low;
	logic sel_change;
	logic conv_tick;
	logic s_done_rise;
	logic busy;

	assign cs_low      = ~cs_sync_q[1];
	assign sel_change  = sel_sync_q[1] ^ sel_prev_q;
	assign conv_tick   = (conv_cnt_q == CONV_W'(CONV_CYC - 1));
	assign s_done_rise = done_sync_q[1] & ~done_prev_q;
	// Word must not change under a reader that may be mid-frame
	assign busy = role_q ? (mstate_q != M_IDLE) : (cs_low & pending_q);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			cs_sync_q   <= 2'h3;
			role_sync_q <= 2'h0;
			sel_sync_q  <= 2'h0;
			done_sync_q <= 2'h0;
			sel_prev_q  <= 1'h0;
			done_prev_q <= 1'h0;
		end else begin
			cs_sync_q   <= {cs_sync_q[0], cs_n_i};
			role_sync_q <= {role_sync_q[0], role_master_i};
			sel_sync_q  <= {sel_sync_q[0], input_pair_select_i};
			done_sync_q <= {done_sync_q[0], s_done_q};
			sel_prev_q  <= sel_sync_q[1];
			done_prev_q <= done_sync_q[1];
		end
	end

	// Role is a strap; it is caught after reset and may follow the pin
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			role_q <= 1'h0;
		end else begin
			role_q <= role_sync_q[1];
		end
	end

	// Conversion timebase; a new input pair restarts the conversion
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || sel_change || conv_tick) begin
			conv_cnt_q <= '0;
		end else begin
			conv_cnt_q <= conv_cnt_q + CONV_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || sel_change) begin
			settle_q <= 2'h0;
		end else if (conv_tick && settle_q != SETTLE_CONVS) begin
			settle_q <= settle_q + 2'h1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			settled_o <= 1'h0;
		end else begin
			settled_o <= (settle_q == SETTLE_CONVS);
		end
	end

	// Result hold; a result that lands during a read is dropped
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			word_q <= '0;
		end else if (conv_tick && !busy && !sel_change &&
				settle_q >= SETTLE_CONVS - 2'h1) begin
			word_q <= result_i;
		end
	end

	// Set wins over the clear by the end of a read
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || sel_change) begin
			pending_q <= 1'h0;
		end else if (conv_tick && !busy &&
				settle_q >= SETTLE_CONVS - 2'h1) begin
			pending_q <= 1'h1;
		end else if (s_done_rise || m_finish) begin
			pending_q <= 1'h0;
		end
	end

	assign m_finish = (mstate_q == M_HIGH) && (half_cnt_q == '0) &&
		(mbit_q == LAST_BIT);

	// Master role: clock made from the crystal-rate divider
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			mstate_q   <= M_IDLE;
			half_cnt_q <= '0;
			mbit_q     <= '0;
			sclk_q     <= 1'h1;
			m_dout_q   <= 1'h1;
		end else if (!role_q || !cs_low) begin
			mstate_q <= M_IDLE;
			sclk_q   <= 1'h1;
			m_dout_q <= ~pending_q;
		end else begin
			unique case (mstate_q)
			M_IDLE: begin
				m_dout_q <= ~pending_q;
				if (pending_q && !m_dout_q) begin
					mstate_q   <= M_LEAD;
					half_cnt_q <= HALF_W'(HALF_CYC - 1);
					mbit_q     <= '0;
				end
			end
			M_LEAD: begin
				if (half_cnt_q != '0) begin
					half_cnt_q <= half_cnt_q - HALF_W'(1);
				end else begin
					sclk_q     <= 1'h0;
					m_dout_q   <= word_q[RESULT_W - 1];
					half_cnt_q <= HALF_W'(HALF_CYC - 1);
					mstate_q   <= M_LOW;
				end
			end
			M_LOW: begin
				if (half_cnt_q != '0) begin
					half_cnt_q <= half_cnt_q - HALF_W'(1);
				end else begin
					sclk_q     <= 1'h1;
					mbit_q     <= mbit_q + BIT_W'(1);
					half_cnt_q <= HALF_W'(HALF_CYC - 1);
					mstate_q   <= M_HIGH;
				end
			end
			M_HIGH: begin
				if (half_cnt_q != '0) begin
					half_cnt_q <= half_cnt_q - HALF_W'(1);
				end else if (mbit_q == LAST_BIT) begin
					m_dout_q <= 1'h1;
					mstate_q <= M_IDLE;
				end else begin
					sclk_q     <= 1'h0;
					m_dout_q   <= word_q[RESULT_W - 1 - 32'(mbit_q)];
					half_cnt_q <= HALF_W'(HALF_CYC - 1);
					mstate_q   <= M_LOW;
				end
			end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sclk_oe_n_o <= 1'h1;
		end else begin
			sclk_oe_n_o <= ~role_q;
		end
	end

	assign sclk_o = sclk_q;

	// Slave role: shifter on the controller's clock. word_q is held
	// still while the frame runs, so it crosses without a synchroniser.
	// Select high clears the frame because the clock stops between reads.
	always_ff @(negedge link_sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			s_cnt_q <= '0;
			s_bit_q <= 1'h1;
		end else if (s_cnt_q != LAST_BIT) begin
			s_bit_q <= word_q[RESULT_W - 1 - 32'(s_cnt_q)];
			s_cnt_q <= s_cnt_q + BIT_W'(1);
		end
	end

	// Relies on the controller parking the clock high before select rises.
	// Cleared by the synchronised select, so the flag outlives a select that
	// rises at once; select must then stay high two reference cycles.
	always_ff @(posedge link_sclk_i or posedge cs_sync_q[1]) begin
		if (cs_sync_q[1]) begin
			s_done_q <= 1'h0;
		end else if (s_cnt_q == LAST_BIT) begin
			s_done_q <= 1'h1;
		end
	end

	// Output pin: slave data driven straight from the edge flops so bit timing
	// is set by the serial clock, not by the 100 ns reference clock
	always_comb begin
		dout_o.oe_n = cs_n_i;
		if (role_q) begin
			dout_o.data = m_dout_q;
		end else if (s_done_q) begin
			dout_o.data = 1'h1;
		end else if (s_cnt_q != '0) begin
			dout_o.data = s_bit_q;
		end else begin
			dout_o.data = ~pending_q;
		end
	end

endmodule

// [adc_readout_serial_port_sva.sv]
`timescale 1ns/1ns
module adc_readout_serial_port_sva
	import adc_readout_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYC_DEF,
	parameter int HALF_CYC = CRYSTAL_TIMEBASE_HALF_CYC
) (
	// Clocks and reset
	input wire logic	ref_clk_i,
	input wire logic	rst_n_i,
	input wire logic	link_sclk_i,
	// Pins
	input wire logic	cs_n_i,
	input wire logic	sclk_o,
	input wire logic	sclk_oe_n_o,
	input wire logic	role_master_i,
	input wire logic	input_pair_select_i,
	input wire logic	settled_o,
	input wire adc_readout_pkg::dout_pin_s	dout_o
);
	localparam int LEAD_LO = HALF_CYC;
	localparam int LEAD_HI = 3 * HALF_CYC;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Ready strobe: data falls while the idle clock sits high
	sequence ready_s;
		$fell(dout_o.data) && sclk_o && $stable(sclk_o) && !sclk_oe_n_o &&
			!dout_o.oe_n;
	endsequence
	sequence drift_s;
		$changed(dout_o.data) && !sclk_o && !sclk_oe_n_o;
	endsequence
	data_enable_a: assert property (dout_o.oe_n == cs_n_i)
		else $error("data enable differs from select");
	slave_role_a: assert property (!role_master_i [*5] |-> sclk_oe_n_o)
		else $error("clock driven in slave role");
	master_role_a: assert property (role_master_i [*5] |-> !sclk_oe_n_o)
		else $error("clock idle in master role");
	low_phase_a: assert property ($fell(sclk_o) |-> ##HALF_CYC $rose(sclk_o))
		else $error("clock low phase wrong");
	high_phase_a: assert property ($rose(sclk_o) |-> sclk_o [*4])
		else $error("clock high phase short");
	first_edge_a: assert property (ready_s |-> ##[LEAD_LO:LEAD_HI] $fell(sclk_o))
		else $error("first clock edge out of range");
	bit_update_a: assert property (drift_s |-> $fell(sclk_o))
		else $error("data moved away from falling edge");
	settle_drop_a: assert property ($changed(input_pair_select_i) |-> ##5 !settled_o [*8])
		else $error("settled kept after select change");
endmodule

bind adc_readout_serial_port adc_readout_serial_port_sva #(
	.CONV_CYC(CONV_CYC),
	.HALF_CYC(HALF_CYC)
) u_sva (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link_sclk_i(link_sclk_i),
	.cs_n_i(cs_n_i), .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n_o),
	.role_master_i(role_master_i), .settled_o(settled_o), .dout_o(dout_o),
	.input_pair_select_i(input_pair_select_i)
);

// [adc_readout_host_model.sv]
`timescale 1ns/1ns
module adc_readout_host_model (
	// From the converter
	input wire logic	sclk_i,
	input wire logic	data_i,
	input wire logic	data_oe_n_i,
	// To the converter
	output logic		link_sclk_o,
	output logic		cs_n_o
);
	logic	last_q;
	logic	line;
	// A released line shows the inverse, so a stale bit never looks valid
	always @(data_i or data_oe_n_i) if (!data_oe_n_i) last_q = data_i;
	assign line = data_oe_n_i ? ~last_q : data_i;
	initial begin
		last_q = 1'b0;
		link_sclk_o = 1'b1;
		// A clean rising select clears the link flops at start
		cs_n_o = 1'b0;
		#1 cs_n_o = 1'b1;
	end
	task automatic read_word(input logic master, output logic [23:0] w,
		output time t_rdy);
		int n;
		n = 0;
		cs_n_o = 1'b0;
		#80;
		while (line !== 1'b0 && n < 20000) begin
			#100;
			n++;
		end
		t_rdy = $time;
		for (int i = 23; i >= 0; i--) begin
			if (master) @(posedge sclk_i);
			else begin
				#6 link_sclk_o = 1'b0;
				#6 link_sclk_o = 1'b1;
			end
			w[i] = line;
		end
	endtask
	task automatic end_frame();
		link_sclk_o = 1'b1;
		cs_n_o = 1'b1;
		// Select stays high long enough for the reference side to see it
		#400;
	endtask
endmodule

// [adc_readout_serial_port_bench.sv]
`timescale 1ns/1ns
module adc_readout_serial_port_bench;
	import adc_readout_pkg::*;
	localparam int CONV = 2000;
	logic			ref_clk_i = 1'b0;
	logic			rst_n_i = 1'b0;
	logic			role_master_i = 1'b0;
	logic			input_pair_select_i = 1'b0;
	logic [23:0]	result_i = 24'ha5c3e0;
	logic			link_sclk_i;
	logic			cs_n_i;
	logic			sclk_o;
	logic			sclk_oe_n_o;
	logic			settled_o;
	dout_pin_s		dout_o;
	int				fail_count = 0;
	int				comparisons = 0;
	logic [23:0]	w;
	time			t0;
	time			t1;
	always #50 ref_clk_i = ~ref_clk_i;
	adc_readout_serial_port #(.CONV_CYC(CONV), .HALF_CYC(4)) u_dut (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link_sclk_i(link_sclk_i),
		.cs_n_i(cs_n_i), .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n_o),
		.dout_o(dout_o), .role_master_i(role_master_i), .result_i(result_i),
		.input_pair_select_i(input_pair_select_i), .settled_o(settled_o)
	);
	adc_readout_host_model u_host (
		.sclk_i(sclk_o), .data_i(dout_o.data), .data_oe_n_i(dout_o.oe_n),
		.link_sclk_o(link_sclk_i), .cs_n_o(cs_n_i)
	);
	task automatic check(string what, logic [23:0] exp, logic [23:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("%0d compared, %0d mismatched", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic t_slave();
		u_host.read_word(1'b0, w, t0);
		check("slave word", 24'ha5c3e0, w);
		#20;
		check("end level", 1, dout_o.data);
		check("drive", 0, dout_o.oe_n);
		u_host.end_frame();
		check("release", 1, dout_o.oe_n);
		@(negedge ref_clk_i) result_i = 24'h5a3c0f;
		u_host.read_word(1'b0, w, t1);
		check("next word", 24'h5a3c0f, w);
		check("period", 1, (t1 - t0) / 100 inside {[CONV - 2:CONV + 2]});
		u_host.end_frame();
		$display("slave test done");
	endtask
	task automatic t_settle();
		@(negedge ref_clk_i) input_pair_select_i = 1'b1;
		t0 = $time;
		u_host.read_word(1'b0, w, t1);
		check("wait", 1, (t1 - t0) / 100 inside {[2 * CONV - 2:2 * CONV + 8]});
		check("settled", 1, settled_o);
		check("settle word", 24'h5a3c0f, w);
		u_host.end_frame();
		$display("settle test done");
	endtask
	task automatic t_master();
		@(negedge ref_clk_i) role_master_i = 1'b1;
		result_i = 24'h3c5a96;
		repeat (5) @(negedge ref_clk_i);
		check("clock enable", 0, sclk_oe_n_o);
		u_host.read_word(1'b1, w, t0);
		check("master word", 24'h3c5a96, w);
		repeat (8) @(negedge ref_clk_i);
		check("end level", 1, dout_o.data);
		u_host.end_frame();
		$display("master test done");
	endtask
	initial begin
		repeat (10) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		check("reset clock", 1, sclk_oe_n_o);
		t_slave();
		t_settle();
		t_master();
		wrap_up();
	end
	// About six conversion periods of work, with ample margin
	initial begin
		#3000000;
		fail_count++;
		wrap_up();
	end
endmodule
